/* File: acp_top.sv */
// Host bus, modem pin and rate clock front end of the serial element
`timescale 1ns/1ps
`include "acp_cfg.svh"
module acp_top (
  // Clock and synchronous reset
  input  wire logic              clock,
  input  wire logic              rst_b,
  input  wire logic              master_reset_in,
  // Host address and selection pins
  input  wire logic              reg_sel_bit0,
  input  wire logic              reg_sel_bit1,
  input  wire logic              reg_sel_bit2,
  input  wire logic              select_latch_strobe_n,
  input  wire logic              chip_sel_hi_a,
  input  wire logic              chip_sel_hi_b,
  input  wire logic              chip_sel_lo_n,
  // Host strobes and data bus
  input  wire logic              read_strobe_low_active_n,
  input  wire logic              read_strobe_high_active,
  input  wire logic              write_strobe_n,
  input  wire acp_pkg::acp_byte_t data_in,
  output acp_pkg::acp_byte_t     data_out,
  output logic                   data_oe,
  output logic                   transceiver_disable_out,
  output logic                   irq_out,
  // Interrupt sources from the rest of the element
  input  wire logic              rx_error_pending,
  input  wire logic              rx_data_pending,
  input  wire logic              rx_timeout_pending,
  input  wire logic              fifo_mode,
  input  wire logic              thr_empty_pending,
  input  wire logic [3:0]        irq_enable,
  // Modem pins
  input  wire logic              cts_n,
  input  wire logic              dsr_n,
  input  wire logic              dcd_n,
  input  wire logic              ri_n,
  output logic                   dtr_n,
  output logic                   rts_n,
  output logic                   out1_n,
  output logic                   out2_n,
  // Transmit gating, receiver clock and divisor
  output logic                   tx_allow,
  input  wire logic              rx_clock_16x,
  output logic                   rx_tick,
  input  wire logic [15:0]       divisor,
  output logic                   tx_rate_clock_out
);
  import acp_pkg::*;

  // ------------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------------
  localparam int NSYNC = 15;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  assign raw_in = {rx_clock_16x, master_reset_in, ri_n, dcd_n, dsr_n,
                   cts_n, write_strobe_n, read_strobe_high_active,
                   read_strobe_low_active_n, chip_sel_lo_n, chip_sel_hi_b,
                   chip_sel_hi_a, select_latch_strobe_n, reg_sel_bit2,
                   reg_sel_bit1};
  // Bit 0 carries reg_sel_bit1; bit0 sampled separately below
  logic [1:0] a0_sync;
  // Reset to idle pin levels so no false change or strobe follows reset
  localparam logic [NSYNC-1:0] SYNC_IDLE = 15'h1F60;

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clock) begin
        if (!rst_b) begin
          sync_a[gi] <= SYNC_IDLE[gi];
          sync_b[gi] <= SYNC_IDLE[gi];
        end else begin
          sync_a[gi] <= raw_in[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      a0_sync <= 2'b00;
    end else begin
      a0_sync <= {a0_sync[0], reg_sel_bit0};
    end
  end

  logic s_a1, s_a2, s_ads_n, s_cs0, s_cs1, s_cs2_n, s_rd_n, s_rd;
  logic s_wr_n, s_cts_n, s_dsr_n, s_dcd_n, s_ri_n, s_mr, s_rclk;
  assign {s_rclk, s_mr, s_ri_n, s_dcd_n, s_dsr_n, s_cts_n, s_wr_n, s_rd,
          s_rd_n, s_cs2_n, s_cs1, s_cs0, s_ads_n, s_a2, s_a1} = sync_b;

  logic rst_all;
  assign rst_all = !rst_b || s_mr;

  // ------------------------------------------------------------------
  // Address strobe latch and chip select
  // ------------------------------------------------------------------
  acp_addr_t held_addr;
  logic      held_cs;
  acp_addr_t sel_addr;
  logic      sel_cs;
  logic      live_cs;

  assign live_cs  = s_cs0 && s_cs1 && !s_cs2_n;
  assign sel_addr = s_ads_n ? held_addr : {s_a2, s_a1, a0_sync[1]};
  assign sel_cs   = s_ads_n ? held_cs : live_cs;

  // Follows the pins while low, so the rising edge leaves the last value
  always_ff @(posedge clock) begin
    if (rst_all) begin
      held_addr <= 3'h0;
      held_cs   <= 1'b0;
    end else if (!s_ads_n) begin
      held_addr <= {s_a2, s_a1, a0_sync[1]};
      held_cs   <= live_cs;
    end
  end

  // ------------------------------------------------------------------
  // Access decode
  // ------------------------------------------------------------------
  function automatic acp_acc_t decode_acc(input logic cs, input logic rd_n,
                                          input logic rd, input logic wr_n);
    if (!cs)
      return ACP_IDLE;
    else if (!rd_n || rd)
      return ACP_READ;
    else if (!wr_n)
      return ACP_WRITE;
    else
      return ACP_IDLE;
  endfunction

  acp_acc_t acc;
  acp_acc_t prev_acc;
  logic     msr_read_done;
  logic     mcr_write;
  assign acc = decode_acc(sel_cs, s_rd_n, s_rd, s_wr_n);

  always_ff @(posedge clock) begin
    if (rst_all) begin
      prev_acc <= ACP_IDLE;
    end else begin
      prev_acc <= acc;
    end
  end

  // Status clears at the end of the read, after the host sampled it
  assign msr_read_done = (prev_acc == ACP_READ) && (acc != ACP_READ) &&
                         (sel_addr == `ACP_ADDR_MSR);
  assign mcr_write = (acc == ACP_WRITE) && (prev_acc != ACP_WRITE) &&
                     (sel_addr == `ACP_ADDR_MCR);

  // ------------------------------------------------------------------
  // Modem control register
  // ------------------------------------------------------------------
  acp_byte_t modem_control_reg;
  always_ff @(posedge clock) begin
    if (rst_all) begin
      modem_control_reg <= `ACP_MCR_RESET;
    end else if (mcr_write) begin
      modem_control_reg <= data_in;
    end
  end

  logic loop_mode;
  assign loop_mode = modem_control_reg[`ACP_MCR_LOOP];

  // Loopback parks every control output high
  always_ff @(posedge clock) begin
    if (rst_all) begin
      dtr_n  <= 1'b1;
      rts_n  <= 1'b1;
      out1_n <= 1'b1;
      out2_n <= 1'b1;
    end else begin
      dtr_n  <= loop_mode || !modem_control_reg[`ACP_MCR_DTR];
      rts_n  <= loop_mode || !modem_control_reg[`ACP_MCR_RTS];
      out1_n <= loop_mode || !modem_control_reg[`ACP_MCR_OUT1];
      out2_n <= loop_mode || !modem_control_reg[`ACP_MCR_OUT2];
    end
  end

  // ------------------------------------------------------------------
  // Modem status with change bits
  // ------------------------------------------------------------------
  logic [3:0] lvl_now;
  logic [3:0] lvl_prev;
  logic [3:0] delta;
  logic [3:0] change;
  logic       auto_cts;

  // In loopback the status reflects the control bits instead of the pins
  assign lvl_now = loop_mode ?
      {modem_control_reg[`ACP_MCR_OUT2], modem_control_reg[`ACP_MCR_OUT1],
       modem_control_reg[`ACP_MCR_DTR], modem_control_reg[`ACP_MCR_RTS]} :
      {!s_dcd_n, !s_ri_n, !s_dsr_n, !s_cts_n};
  assign auto_cts = modem_control_reg[`ACP_MCR_AFE];

  always_ff @(posedge clock) begin
    if (rst_all) begin
      lvl_prev <= 4'h0;
    end else begin
      lvl_prev <= lvl_now;
    end
  end

  // Order dcd, ri, dsr, cts; ring change only on trailing edge
  assign change = {lvl_now[3] ^ lvl_prev[3],
                   lvl_prev[2] && !lvl_now[2],
                   lvl_now[1] ^ lvl_prev[1],
                   lvl_now[0] ^ lvl_prev[0]};

  // A change in the clearing cycle survives the clear
  always_ff @(posedge clock) begin
    if (rst_all) begin
      delta <= 4'h0;
    end else if (msr_read_done) begin
      delta <= change;
    end else begin
      delta <= delta | change;
    end
  end

  acp_byte_t msr_value;
  assign msr_value = {lvl_now[3], lvl_now[2], lvl_now[1], lvl_now[0],
                      delta[3], delta[2], delta[1], delta[0]};

  // ------------------------------------------------------------------
  // Host data bus and driver disable
  // ------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst_all) begin
      data_out                <= 8'h00;
      data_oe                 <= 1'b0;
      transceiver_disable_out <= 1'b1;
    end else begin
      data_oe                 <= (acc == ACP_READ);
      transceiver_disable_out <= (acc != ACP_READ);
      case (sel_addr)
        `ACP_ADDR_MSR: data_out <= msr_value;
        `ACP_ADDR_MCR: data_out <= modem_control_reg;
        default:       data_out <= 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Interrupt and transmit gating
  // ------------------------------------------------------------------
  logic modem_irq;
  // Clear-to-send changes stay quiet while hardware owns the transmitter
  assign modem_irq = irq_enable[`ACP_IER_MSI] &&
      (|delta[3:1] || (delta[0] && !auto_cts));

  always_ff @(posedge clock) begin
    if (rst_all) begin
      irq_out  <= 1'b0;
      tx_allow <= 1'b1;
    end else begin
      irq_out  <= (irq_enable[2] && rx_error_pending) ||
                  (irq_enable[0] && (rx_data_pending ||
                   (fifo_mode && rx_timeout_pending))) ||
                  (irq_enable[1] && thr_empty_pending) ||
                  modem_irq;
      tx_allow <= !auto_cts || lvl_now[0];
    end
  end

  // ------------------------------------------------------------------
  // Rate clocks
  // ------------------------------------------------------------------
  logic rate_tick;
  logic rclk_prev;
  acp_baud_div #(
    .WIDTH(16)
  ) u_div (
    .clock     (clock),
    .rst_b     (!rst_all),
    .divisor   (divisor),
    .rate_tick (rate_tick)
  );

  always_ff @(posedge clock) begin
    if (rst_all) begin
      tx_rate_clock_out <= 1'b0;
      rclk_prev         <= 1'b0;
      rx_tick           <= 1'b0;
    end else begin
      tx_rate_clock_out <= rate_tick;
      rclk_prev         <= s_rclk;
      rx_tick           <= s_rclk && !rclk_prev;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  property p_transceiver_disable_out;
    @(posedge clock) disable iff (rst_all)
      (acc == ACP_READ) |=> !transceiver_disable_out && data_oe;
  endproperty
  a_transceiver_disable_out: assert property (p_transceiver_disable_out) else $error("transceiver_disable_out not low on read");

  property p_nosel;
    @(posedge clock) disable iff (rst_all)
      !sel_cs |=> !data_oe;
  endproperty
  a_nosel: assert property (p_nosel) else $error("bus driven unselected");

  property p_dtr;
    @(posedge clock) disable iff (rst_all)
      loop_mode |=> dtr_n;
  endproperty
  a_dtr: assert property (p_dtr) else $error("dtr active in loop");

  property p_dcts;
    @(posedge clock) disable iff (rst_all)
      (change[0] && !msr_read_done) ##1 !msr_read_done [*3]
        |-> delta[0];
  endproperty
  a_dcts: assert property (p_dcts) else $error("cts change lost");

  property p_ddcd;
    @(posedge clock) disable iff (rst_all)
      change[3] |=> delta[3];
  endproperty
  a_ddcd: assert property (p_ddcd) else $error("dcd change lost");

  property p_ddsr;
    @(posedge clock) disable iff (rst_all)
      change[1] |=> delta[1];
  endproperty
  a_ddsr: assert property (p_ddsr) else $error("dsr change lost");

  property p_autocts;
    @(posedge clock) disable iff (rst_all)
      (auto_cts && !lvl_now[0]) |=> !tx_allow;
  endproperty
  a_autocts: assert property (p_autocts) else $error("tx not gated");

  property p_ctsirq;
    @(posedge clock) disable iff (rst_all)
      (auto_cts && delta[0] && !(|delta[3:1]) && !rx_error_pending &&
       !rx_data_pending && !rx_timeout_pending && !thr_empty_pending)
        |=> !irq_out;
  endproperty
  a_ctsirq: assert property (p_ctsirq) else $error("cts irq in auto");
endmodule

/* File: acp_cfg.svh */
// Constants for the host-pin and modem-pin front end of the serial element
// Operation
// - Register-select inputs choose the accessed register
// - Strobe low passes selects, high holds
// - Selected only when high, high, low
// - Clear-to-send in bit 4, change bit 0
// - Clear-to-send interrupt only without auto flow
// - Auto mode lets clear-to-send gate transmitter
// - Carrier in bit 7, change bit 3
// - Set-ready in bit 5, change bit 1
// - Terminal-ready follows control bit, off in loopback
// - Driver disable high unless host reads
// - Interrupt output for four cause groups
// - Interrupt drops when serviced or reset
// - Master reset clears registers and outputs
// - Rate clock is reference over divisor
// - Eight-bit data bus, tri-stated when idle
// - Either read strobe reads while selected
// - Receiver runs from separate sixteen-times clock
`ifndef ACP_CFG_SVH
`define ACP_CFG_SVH
`define ACP_MSR_DCTS      0
`define ACP_MSR_DDSR      1
`define ACP_MSR_TERI      2
`define ACP_MSR_DDCD      3
`define ACP_MSR_CTS       4
`define ACP_MSR_DSR       5
`define ACP_MSR_RI        6
`define ACP_MSR_DCD       7
`define ACP_MCR_DTR       0
`define ACP_MCR_RTS       1
`define ACP_MCR_OUT1      2
`define ACP_MCR_OUT2      3
`define ACP_MCR_LOOP      4
`define ACP_MCR_AFE       5
`define ACP_IER_MSI       3
`define ACP_ADDR_MCR      3'h4
`define ACP_ADDR_MSR      3'h6
`define ACP_MCR_RESET     8'h00
`define ACP_DIV_RESET     16'h0001
`endif

/* File: acp_pkg.sv */
// Types shared by the serial element front end
package acp_pkg;
  typedef logic [7:0] acp_byte_t;
  typedef logic [2:0] acp_addr_t;
  typedef enum logic [1:0] {ACP_IDLE, ACP_READ, ACP_WRITE} acp_acc_t;
endpackage

/* File: acp_baud_div.sv */
// Baud rate divider producing the sixteen-times transmit rate clock
`timescale 1ns/1ps
`include "acp_cfg.svh"
module acp_baud_div #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_b,
  // Divisor and output
  input  wire logic [WIDTH-1:0] divisor,
  output logic                  rate_tick
);
  logic [WIDTH-1:0] count;

  // Zero divisor treated as one so the tick never stalls
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      count     <= '0;
      rate_tick <= 1'b0;
    end else if (count + 1'b1 >= divisor) begin
      count     <= '0;
      rate_tick <= 1'b1;
    end else begin
      count     <= count + 1'b1;
      rate_tick <= 1'b0;
    end
  end
endmodule

/* File: acp_modem_model.sv */
// Behavioural modem and clock loop on the far side of the element
`timescale 1ns/1ps
module acp_modem_model (
  // Rate clock loop
  input  wire logic tx_rate_clock_out,
  output logic      rx_clock_16x,
  // Modem status pins, active low
  output logic      cts_n,
  output logic      dsr_n,
  output logic      dcd_n,
  output logic      ri_n
);
  // ------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------
  // Receiver shares the transmit rate on this board
  assign rx_clock_16x = tx_rate_clock_out;

  initial begin
    {cts_n, dsr_n, dcd_n, ri_n} = 4'hF;
  end

  // Caller enters just after a clock edge, never on it
  task automatic set_pins(input logic [3:0] v);
    {cts_n, dsr_n, dcd_n, ri_n} = v;
  endtask
endmodule

/* File: test_acp_top.sv */
// Self-checking bench for the host and modem pin front end
`timescale 1ns/1ps
module test_acp_top;
  import acp_pkg::*;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic master_reset_in = 1'b0;
  logic reg_sel_bit0 = 1'b0, reg_sel_bit1 = 1'b0, reg_sel_bit2 = 1'b0;
  logic select_latch_strobe_n = 1'b0;
  logic chip_sel_hi_a = 1'b1, chip_sel_hi_b = 1'b1, chip_sel_lo_n = 1'b1;
  logic read_strobe_low_active_n = 1'b1;
  logic read_strobe_high_active = 1'b0;
  logic write_strobe_n = 1'b1;
  acp_byte_t data_in = 8'h00;
  acp_byte_t data_out;
  logic data_oe, transceiver_disable_out, irq_out;
  logic rx_error_pending = 1'b0, rx_data_pending = 1'b0;
  logic rx_timeout_pending = 1'b0, fifo_mode = 1'b0;
  logic thr_empty_pending = 1'b0;
  logic [3:0] irq_enable = 4'h0;
  logic cts_n, dsr_n, dcd_n, ri_n;
  logic dtr_n, rts_n, out1_n, out2_n, tx_allow;
  logic rx_clock_16x, rx_tick, tx_rate_clock_out;
  logic [15:0] divisor = 16'h0004;
  int n_mismatch = 0;
  int tests_run = 0;
  acp_byte_t rd_data;
  logic rd_oe, rd_transceiver_disable_out;
  logic [7:0] n_tx, n_rx;
  logic [4:0] src [5] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h18};
  logic [4:0] irq_exp = 5'b10111;

  always #4 clock = ~clock;

  acp_top i_acp_top (.clock, .rst_b, .master_reset_in, .reg_sel_bit0,
    .reg_sel_bit1, .reg_sel_bit2, .select_latch_strobe_n, .chip_sel_hi_a,
    .chip_sel_hi_b, .chip_sel_lo_n, .read_strobe_low_active_n,
    .read_strobe_high_active, .write_strobe_n, .data_in, .data_out,
    .data_oe, .transceiver_disable_out, .irq_out, .rx_error_pending,
    .rx_data_pending, .rx_timeout_pending, .fifo_mode, .thr_empty_pending,
    .irq_enable, .cts_n, .dsr_n, .dcd_n, .ri_n, .dtr_n, .rts_n, .out1_n,
    .out2_n, .tx_allow, .rx_clock_16x, .rx_tick, .divisor,
    .tx_rate_clock_out);

  acp_modem_model i_acp_modem_model (.tx_rate_clock_out, .rx_clock_16x,
    .cts_n, .dsr_n, .dcd_n, .ri_n);

  // ------------------------------------------------------------
  // Host access tasks
  // ------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // Selects {hi_a, hi_b, lo_n}; pins pass a two-flop sync first
  task automatic rd(input logic [2:0] a, input logic [2:0] cs,
                    input logic hi);
    {reg_sel_bit2, reg_sel_bit1, reg_sel_bit0} = a;
    {chip_sel_hi_a, chip_sel_hi_b, chip_sel_lo_n} = cs;
    if (hi) begin
      read_strobe_high_active = 1'b1;
    end else begin
      read_strobe_low_active_n = 1'b0;
    end
    cyc(4);
    rd_data = data_out;
    rd_oe = data_oe;
    rd_transceiver_disable_out = transceiver_disable_out;
    read_strobe_high_active = 1'b0;
    read_strobe_low_active_n = 1'b1;
    {chip_sel_hi_a, chip_sel_hi_b, chip_sel_lo_n} = 3'h7;
    cyc(4);
  endtask

  task automatic wr(input logic [2:0] a, input acp_byte_t d);
    {reg_sel_bit2, reg_sel_bit1, reg_sel_bit0} = a;
    chip_sel_lo_n = 1'b0;
    data_in = d;
    write_strobe_n = 1'b0;
    cyc(4);
    write_strobe_n = 1'b1;
    chip_sel_lo_n = 1'b1;
    cyc(4);
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Whole run is well under a thousand cycles
  initial begin
    #100_000;
    n_mismatch++;
    end_sim;
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    cyc(10);
    rst_b = 1'b1;
    cyc(1);
    check(transceiver_disable_out, 1'b1);
    check({data_oe, irq_out, dtr_n, tx_allow}, 4'h3);
    done("reset");

    rd(3'h6, 3'h6, 1'b0);
    check({rd_oe, rd_transceiver_disable_out}, 2'h2);
    i_acp_modem_model.set_pins(4'h7);
    cyc(6);
    rd(3'h6, 3'h6, 1'b1);
    check(rd_data, 8'h11);
    rd(3'h6, 3'h6, 1'b0);
    check(rd_data, 8'h10);
    i_acp_modem_model.set_pins(4'h1);
    cyc(6);
    rd(3'h6, 3'h6, 1'b0);
    check(rd_data, 8'hBA);
    rd(3'h6, 3'h6, 1'b0);
    check(rd_data, 8'hB0);
    done("status");

    foreach (src[i]) begin
      if (i < 3) begin
        rd(3'h6, 3'(7 - 2 * i), 1'b0);
        check({rd_oe, rd_transceiver_disable_out}, 2'h1);
      end
    end
    done("select");

    wr(3'h4, 8'h01);
    check(dtr_n, 1'b0);
    wr(3'h4, 8'h11);
    check(dtr_n, 1'b1);
    wr(3'h4, 8'h00);
    check(dtr_n, 1'b1);
    done("control");
    // Loopback toggled the status levels; drain those change bits first
    rd(3'h6, 3'h6, 1'b0);

    irq_enable = 4'h8;
    i_acp_modem_model.set_pins(4'h3);
    cyc(6);
    check(irq_out, 1'b1);
    rd(3'h6, 3'h6, 1'b0);
    check(rd_data, 8'h38);
    check(irq_out, 1'b0);
    wr(3'h4, 8'h20);
    i_acp_modem_model.set_pins(4'hB);
    cyc(6);
    check({irq_out, tx_allow}, 2'h0);
    i_acp_modem_model.set_pins(4'h3);
    cyc(6);
    check(tx_allow, 1'b1);
    rd(3'h6, 3'h6, 1'b0);
    check(rd_data, 8'h31);
    wr(3'h4, 8'h00);
    done("modem irq");

    irq_enable = 4'h7;
    foreach (src[i]) begin
      {fifo_mode, rx_timeout_pending, thr_empty_pending, rx_data_pending,
       rx_error_pending} = src[i];
      cyc(3);
      check(irq_out, irq_exp[i]);
      {fifo_mode, rx_timeout_pending, thr_empty_pending, rx_data_pending,
       rx_error_pending} = 5'h00;
      cyc(3);
      check(irq_out, 1'b0);
    end
    irq_enable = 4'h0;
    rx_data_pending = 1'b1;
    cyc(3);
    check(irq_out, 1'b0);
    rx_data_pending = 1'b0;
    done("irq causes");

    // Latched select must survive the pins going away
    {reg_sel_bit2, reg_sel_bit1, reg_sel_bit0} = 3'h6;
    chip_sel_lo_n = 1'b0;
    cyc(2);
    select_latch_strobe_n = 1'b1;
    cyc(1);
    {reg_sel_bit2, reg_sel_bit1, reg_sel_bit0} = 3'h0;
    chip_sel_lo_n = 1'b1;
    read_strobe_low_active_n = 1'b0;
    cyc(4);
    check({7'h00, data_oe}, 8'h01);
    check(data_out, 8'h30);
    read_strobe_low_active_n = 1'b1;
    cyc(4);
    select_latch_strobe_n = 1'b0;
    cyc(4);
    done("latch");

    for (int d = 4; d < 6; d++) begin
      divisor = 16'(d);
      cyc(12);
      n_tx = 8'h00;
      n_rx = 8'h00;
      repeat (40) begin
        cyc(1);
        n_tx = n_tx + {7'h00, tx_rate_clock_out};
        n_rx = n_rx + {7'h00, rx_tick};
      end
      check(n_tx, 8'(40 / d));
      check(n_rx, 8'(40 / d));
    end
    done("rate");

    wr(3'h4, 8'h03);
    check({dtr_n, rts_n}, 2'h0);
    master_reset_in = 1'b1;
    cyc(4);
    check({dtr_n, rts_n, irq_out}, 3'h6);
    master_reset_in = 1'b0;
    cyc(4);
    check({dtr_n, transceiver_disable_out}, 2'h3);
    done("master reset");
    end_sim;
  end
endmodule
